// *** inc/dpbcd_params.svh ***
`ifndef DPBCD_PARAMS_SVH
`define DPBCD_PARAMS_SVH
`define DPBCD_MODE_LSB 0
`define DPBCD_MODE_MSB 2
`define DPBCD_PHAND_LSB 5
`define DPBCD_PHAND_MSB 6
`define DPBCD_PMEM_BIT 7
`define DPBCD_STROKE_BIT 0
`define DPBCD_EXTON_BIT 1
`define DPBCD_STOP_BIT 2
`define DPBCD_BATCH_BIT 4
`define DPBCD_SPDAUTO_BIT 5
`define DPBCD_SLOW_BIT 6
`define DPBCD_ARST_BIT 7
`define DPBCD_CNT_ZERO_BIT 0
`define DPBCD_CNT_HOLD_BIT 1
`define DPBCD_FREQ_MIN 8'h1E
`define DPBCD_FREQ_MAX 8'h64
`define DPBCD_SINGLE_MIN 16'h001E
`define DPBCD_ADDR_RST 7'h14
`define DPBCD_DIGIT_MAX 4'h9
`define DPBCD_TIMEOUT_S 30
`define DPBCD_CLK_HZ 100000000
`define DPBCD_TIMEOUT_CYC (64'(`DPBCD_TIMEOUT_S) * 64'(`DPBCD_CLK_HZ))
`endif

// *** inc/dpbcd_pkg.sv ***
package dpbcd_pkg;
  typedef enum logic [2:0] {OPM_NONE = 3'h0, OPM_PULSE = 3'h1, OPM_ANALOG = 3'h2, OPM_BATCH = 3'h3,
    OPM_EXT = 3'h4} dpbcd_mode_t;
  typedef enum logic [1:0] {PH_REDUCE = 2'h0, PH_ONE = 2'h1, PH_MULT = 2'h2} dpbcd_pulse_t;
  typedef enum logic [2:0] {PK_NONE = 3'h0, PK_FACTOR = 3'h1, PK_STROKE_PCT = 3'h2, PK_FLOW_LH = 3'h3,
    PK_STROKE_CNT = 3'h4, PK_VOLUME_L = 3'h5} dpbcd_preset_t;
  typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_EDIT = 2'b10} dpbcd_state_t;
endpackage : dpbcd_pkg

// *** verilog/dpbcd_decoder.sv ***
// Contract
// R1 - ENTER starts entry; UP/DOWN edit flashing digit; ENTER confirms; save after last.
// R2 - UP and DOWN together abandon entry and keep the stored value.
// R3 - Thirty seconds without a key during entry leaves entry, value kept.
// R4 - Two modes, manual and bus; the bus image acts only in bus mode.
// R5 - A changed station address restarts the decoder on the new address.
// R6 - The command image has nine bytes; bytes 3-4 and 8-9 are 16-bit; the decoder takes only bytes 1-7.
// R7 - Byte 1 bits 0-2 pick the mode; none or invalid codes mean fail-safe.
// R8 - Byte 1 bits 5-6 pick reduction, one-to-one or multiplication.
// R9 - Byte 1 bit 7 enables the pulse memory.
// R10 - In pulse mode each rising byte 2 bit 0 fires one stroke.
// R11 - Byte 2 bit 1 runs external-on; bit 2 stops outside manual mode.
// R12 - A rising byte 2 bit 4 starts one batch.
// R13 - Speed variant: bit 5 auto/single, below 30 percent single; bit 6 limits speed.
// R14 - A rising byte 2 bit 7 resets the pending alarm.
// R15 - Bytes 3-4 meaning follows the mode and the calibration state.
// R16 - Calibrated flow and volume take their decimal point from the reported scale.
// R17 - Byte 5 is batch stroke frequency, 30 to 100 percent.
// R18 - Manual mode has no bus settings; a calibrated pump is set in l/h.
// R19 - Byte 6 is slow-mode frequency, 30 to 100, speed variant only.
// R20 - Byte 7 bit 0 holds the counter at zero; bit 1 freezes its report.
// R21 - Edges come from comparing each new image with the previous one.
// R22 - The master holds an edge bit low for one image before raising it.
`include "dpbcd_params.svh"
module dpbcd_decoder
  import dpbcd_pkg::*;
#(
  parameter logic [31:0] TIMEOUT_CYC = 32'(`DPBCD_TIMEOUT_CYC)
)
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic img_valid,
  input wire logic [7:0] img_b1,
  input wire logic [7:0] img_b2,
  input wire logic [15:0] img_preset,
  input wire logic [7:0] img_batch_freq,
  input wire logic [7:0] img_slow_freq,
  input wire logic [7:0] img_b7,
  input wire logic calibrated,
  input wire logic speed_variant,
  input wire logic [7:0] scale_factor,
  input wire logic key_enter_pin,
  input wire logic key_up_pin,
  input wire logic key_down_pin,
  input wire logic entry_sel,
  output logic bus_mode,
  output logic [6:0] station_addr,
  output logic restart_req,
  output logic entry_active,
  output logic entry_digit,
  output logic [3:0] entry_figure,
  output dpbcd_mode_t op_mode,
  output logic fail_safe,
  output dpbcd_pulse_t pulse_handling,
  output logic pulse_mem_en,
  output logic stroke_pulse,
  output logic batch_start,
  output logic alarm_reset,
  output logic ext_on,
  output logic ext_stop,
  output logic speed_auto,
  output logic slow_mode,
  output logic single_30,
  output logic [15:0] preset_value,
  output dpbcd_preset_t preset_kind,
  output logic [7:0] preset_dp,
  output logic [7:0] batch_freq,
  output logic batch_freq_err,
  output logic [7:0] slow_freq,
  output logic cnt_zero,
  output logic cnt_freeze,
  output logic local_flow_set
);
  // Key pins are asynchronous: bit 0 enter, bit 1 up, bit 2 down.
  logic [2:0] key_s1, key_s2, key_s3, key_rise;
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_key
      always_ff @(posedge clk_sys)
      begin
        if (sys_rst)
        begin
          key_s1[gi] <= 1'b0;
          key_s2[gi] <= 1'b0;
          key_s3[gi] <= 1'b0;
        end
        else if (clk_en)
        begin
          key_s1[gi] <= (gi == 0) ? key_enter_pin : ((gi == 1) ? key_up_pin : key_down_pin);
          key_s2[gi] <= key_s1[gi];
          key_s3[gi] <= key_s2[gi];
        end
      end
      assign key_rise[gi] = key_s2[gi] & ~key_s3[gi];
    end
  endgenerate

  logic enter_rise, abort, step_up, step_down;
  assign enter_rise = key_rise[0];
  // A second key joining one already held counts as the combined press.
  assign abort = key_s2[1] & key_s2[2] & (key_rise[1] | key_rise[2]);
  assign step_up = key_rise[1] & ~key_s2[2];
  assign step_down = key_rise[2] & ~key_s2[1];

  dpbcd_state_t state, next_state;
  logic sel, next_sel;
  logic digit, next_digit;
  logic [3:0] fig [2];
  logic [3:0] next_fig [2];
  logic [31:0] timer, next_timer;
  logic mode_set, next_mode_set;
  logic [6:0] addr, next_addr;
  logic restart, next_restart;
  logic [3:0] fmax;
  logic [6:0] new_addr;

  always_comb
  begin
    next_state = state;
    next_sel = sel;
    next_digit = digit;
    next_fig = fig;
    next_timer = timer;
    next_mode_set = mode_set;
    next_addr = addr;
    next_restart = 1'b0;
    fmax = sel ? `DPBCD_DIGIT_MAX : 4'h1;
    new_addr = 7'(fig[0]) * 7'hA + 7'(fig[1]);
    case (state)
      ST_IDLE:
      begin
        if (enter_rise) // R1
        begin
          next_state = ST_EDIT;
          next_sel = entry_sel;
          next_digit = 1'b0;
          next_timer = 32'h0;
          next_fig[0] = entry_sel ? 4'(addr / 7'hA) : {3'h0, mode_set};
          next_fig[1] = 4'(addr % 7'hA);
        end
      end
      ST_EDIT:
      begin
        next_timer = (|key_rise) ? 32'h0 : timer + 32'h1; // R3
        if (abort) // R2
          next_state = ST_IDLE;
        else if (!(|key_rise) && timer >= TIMEOUT_CYC - 32'h1) // R3
          next_state = ST_IDLE;
        else if (step_up) // R1
          next_fig[digit] = (fig[digit] >= fmax) ? 4'h0 : fig[digit] + 4'h1;
        else if (step_down)
          next_fig[digit] = (fig[digit] == 4'h0) ? fmax : fig[digit] - 4'h1;
        else if (enter_rise)
        begin
          if (!sel) // R4
          begin
            next_mode_set = fig[0][0];
            next_state = ST_IDLE;
          end
          else if (!digit)
            next_digit = 1'b1;
          else
          begin
            next_state = ST_IDLE;
            next_addr = new_addr;
            next_restart = (new_addr != addr); // R5
          end
        end
      end
      default:
        next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      state <= ST_IDLE;
      fig <= '{4'h0, 4'h0};
      {sel, digit, timer, mode_set, restart} <= '0;
      addr <= `DPBCD_ADDR_RST;
    end
    else if (clk_en)
    begin
      state <= next_state;
      sel <= next_sel;
      digit <= next_digit;
      fig <= next_fig;
      timer <= next_timer;
      mode_set <= next_mode_set;
      addr <= next_addr;
      restart <= next_restart;
    end
  end

  // Held image; the restart drops it so the new station starts from a clean image.
  logic [7:0] b1, b2, b5, b6, b7;
  logic [7:0] next_b1, next_b2, next_b5, next_b6, next_b7;
  logic [15:0] pre, next_pre;
  logic [2:0] armed, next_armed;
  logic [2:0] edge_q, next_edge;
  logic [2:0] new_bits;

  always_comb
  begin
    new_bits = {img_b2[`DPBCD_ARST_BIT], img_b2[`DPBCD_BATCH_BIT], img_b2[`DPBCD_STROKE_BIT]};
    next_b1 = img_valid ? img_b1 : b1; // R6
    next_b2 = img_valid ? img_b2 : b2;
    next_pre = img_valid ? img_preset : pre;
    next_b5 = img_valid ? img_batch_freq : b5;
    next_b6 = img_valid ? img_slow_freq : b6;
    next_b7 = img_valid ? img_b7 : b7;
    next_edge = img_valid ? (new_bits & armed) : 3'h0; // R21
    next_armed = img_valid ? ~new_bits : armed; // R22
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst || (clk_en && restart))
    begin
      {b1, b2, pre, b5, b6, b7, edge_q, armed} <= '0;
    end
    else if (clk_en)
    begin
      {b1, b2, pre, b5, b6, b7, edge_q, armed} <= {next_b1, next_b2, next_pre, next_b5, next_b6, next_b7,
        next_edge, next_armed};
    end
  end

  dpbcd_mode_t dec_mode;
  dpbcd_preset_t kind;
  logic [2:0] mcode;
  logic [1:0] hcode;
  logic n_bus, n_fs, n_pm, n_stroke, n_batch, n_arst, n_on, n_stop, n_auto, n_slow, n_s30, n_zero, n_frz;
  logic n_ferr, n_lflow;
  dpbcd_mode_t n_mode;
  dpbcd_pulse_t n_ph;
  logic [15:0] n_pre;
  logic [7:0] n_dp, n_bf, n_sf;

  always_comb
  begin
    mcode = b1[`DPBCD_MODE_MSB:`DPBCD_MODE_LSB];
    hcode = b1[`DPBCD_PHAND_MSB:`DPBCD_PHAND_LSB];
    dec_mode = (mcode <= 3'h4) ? dpbcd_mode_t'(mcode) : OPM_NONE; // R7
    case (dec_mode) // R15
      OPM_PULSE: kind = PK_FACTOR;
      OPM_ANALOG: kind = calibrated ? PK_FLOW_LH : PK_STROKE_PCT;
      OPM_BATCH: kind = calibrated ? PK_VOLUME_L : PK_STROKE_CNT;
      OPM_EXT: kind = PK_STROKE_PCT;
      default: kind = PK_NONE;
    endcase
    n_bus = mode_set;
    n_mode = n_bus ? dec_mode : OPM_NONE; // R4
    n_fs = n_bus && dec_mode == OPM_NONE; // R7
    n_ph = !n_bus ? PH_REDUCE : (hcode == 2'h0 ? PH_REDUCE : (hcode == 2'h1 ? PH_ONE : PH_MULT)); // R8
    n_pm = n_bus & b1[`DPBCD_PMEM_BIT]; // R9
    n_stroke = n_bus && dec_mode == OPM_PULSE && edge_q[0]; // R10
    n_batch = n_bus && dec_mode == OPM_BATCH && edge_q[1]; // R12
    n_arst = n_bus & edge_q[2]; // R14
    n_stop = n_bus & b2[`DPBCD_STOP_BIT]; // R11
    n_on = n_bus && dec_mode == OPM_EXT && b2[`DPBCD_EXTON_BIT] && !n_stop; // R11
    n_auto = n_bus & speed_variant & b2[`DPBCD_SPDAUTO_BIT]; // R13
    n_slow = n_bus & speed_variant & b2[`DPBCD_SLOW_BIT]; // R13
    // In auto speed mode, stroke-percent presets below the minimum fall back to single strokes; a preset at the minimum does not.
    n_s30 = n_auto && kind == PK_STROKE_PCT && pre < `DPBCD_SINGLE_MIN; // R13
    n_pre = n_bus ? pre : 16'h0000;
    n_dp = (n_bus && (kind == PK_FLOW_LH || kind == PK_VOLUME_L)) ? scale_factor : 8'h00; // R16
    n_bf = n_bus ? b5 : 8'h00; // R17
    n_ferr = n_bus && dec_mode == OPM_BATCH && (b5 < `DPBCD_FREQ_MIN || b5 > `DPBCD_FREQ_MAX); // R17
    n_sf = (n_bus && speed_variant) ? b6 : 8'h00; // R19
    n_zero = n_bus & b7[`DPBCD_CNT_ZERO_BIT]; // R20
    n_frz = n_bus & b7[`DPBCD_CNT_HOLD_BIT] & ~n_zero; // R20
    n_lflow = !n_bus & calibrated; // R18
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      op_mode <= OPM_NONE;
      pulse_handling <= PH_REDUCE;
      preset_kind <= PK_NONE;
      {bus_mode, fail_safe, pulse_mem_en, stroke_pulse, batch_start, alarm_reset, ext_on, ext_stop, speed_auto,
        slow_mode, single_30, preset_value, preset_dp, batch_freq, batch_freq_err, slow_freq, cnt_zero, cnt_freeze,
        local_flow_set} <= '0;
    end
    else if (clk_en)
    begin
      op_mode <= n_mode;
      pulse_handling <= n_ph;
      preset_kind <= n_bus ? kind : PK_NONE;
      {bus_mode, fail_safe, pulse_mem_en, stroke_pulse, batch_start, alarm_reset, ext_on, ext_stop, speed_auto,
        slow_mode, single_30, preset_value, preset_dp, batch_freq, batch_freq_err, slow_freq, cnt_zero, cnt_freeze,
        local_flow_set} <= {n_bus, n_fs, n_pm, n_stroke, n_batch, n_arst, n_on, n_stop, n_auto, n_slow, n_s30, n_pre,
        n_dp, n_bf, n_ferr, n_sf, n_zero, n_frz, n_lflow};
    end
  end

  assign station_addr = addr;
  assign restart_req = restart;
  assign entry_active = (state == ST_EDIT);
  assign entry_digit = digit;
  assign entry_figure = fig[digit];

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst || !clk_en);

  a_entry_start: assert property (state == ST_IDLE && enter_rise |=> state == ST_EDIT && !digit) // R1
    else $error("entry did not open on enter");
  a_abort_keeps: assert property (state == ST_EDIT && abort |=> state == ST_IDLE && !restart && $stable(addr)) // R2
    else $error("abort changed the stored value");
  a_timeout_exit: assert property (state == ST_EDIT && timer >= TIMEOUT_CYC - 32'h1 && !(|key_rise) // R3
    |=> state == ST_IDLE && $stable(addr) && $stable(mode_set))
    else $error("entry timeout not taken");
  a_manual_quiet: assert property (!bus_mode |-> !ext_stop && !ext_on && !batch_start && !fail_safe) // R4
    else $error("bus image acted in manual mode");
  a_restart_addr: assert property (restart |-> addr != $past(addr) ##1 b1 == 8'h00 && armed == 3'h0) // R5
    else $error("restart without address change");
  a_fail_safe: assert property (bus_mode && op_mode == OPM_NONE |-> fail_safe) // R7
    else $error("fail-safe not raised");
  a_stroke_once: assert property (img_valid && img_b2[0] && armed[0] && mode_set && !restart // R10
    && img_b1[`DPBCD_MODE_MSB:`DPBCD_MODE_LSB] == 3'h1 |=> ##1 stroke_pulse ##1 !stroke_pulse)
    else $error("stroke edge not a single pulse");
  a_stroke_mode: assert property (stroke_pulse |-> bus_mode && op_mode == OPM_PULSE) // R10
    else $error("stroke outside pulse mode");
  a_freq_err: assert property (batch_freq_err |-> batch_freq < `DPBCD_FREQ_MIN || batch_freq > `DPBCD_FREQ_MAX) // R17
    else $error("batch frequency flagged inside range");
  a_cnt_excl: assert property (cnt_zero |-> !cnt_freeze) // R20
    else $error("counter zero and freeze together");

  c_stroke: cover property (stroke_pulse);
  c_abort: cover property (state == ST_EDIT && abort);
  c_restart: cover property (restart);
  c_batch: cover property (batch_start);
endmodule : dpbcd_decoder

// *** verif/dpbcd_master.sv ***
module dpbcd_master
(
  input wire logic clk_sys,
  output logic img_valid,
  output logic [7:0] img_b1,
  output logic [7:0] img_b2,
  output logic [15:0] img_preset,
  output logic [7:0] img_batch_freq,
  output logic [7:0] img_slow_freq,
  output logic [7:0] img_b7
);
  timeunit 1ns;
  timeprecision 1ns;

  initial
  begin
    img_valid = 1'b0;
    {img_b1, img_b2, img_preset, img_batch_freq, img_slow_freq, img_b7} = '0;
  end

  // Between images the lines carry the inverse of the last one, so a late read shows up as wrong data.
  task automatic send(input logic [55:0] img);
    @(posedge clk_sys);
    #1;
    img_valid = 1'b1;
    {img_b1, img_b2, img_preset, img_batch_freq, img_slow_freq, img_b7} = img;
    @(posedge clk_sys);
    #1;
    img_valid = 1'b0;
    {img_b1, img_b2, img_preset, img_batch_freq, img_slow_freq, img_b7} = ~img;
  endtask : send
endmodule : dpbcd_master

// *** verif/tb.sv ***
module tb
  import dpbcd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys, sys_rst, clk_en, img_valid, calibrated, speed_variant, entry_sel;
  logic [7:0] img_b1, img_b2, img_batch_freq, img_slow_freq, img_b7, scale_factor, batch_freq, slow_freq, preset_dp;
  logic [15:0] img_preset, preset_value;
  logic [2:0] keys;
  logic [6:0] station_addr;
  logic bus_mode, restart_req, entry_active, fail_safe, pulse_mem_en, stroke_pulse, batch_start, alarm_reset;
  logic ext_on, ext_stop, batch_freq_err, cnt_zero, cnt_freeze;
  logic speed_auto, slow_mode, single_30, local_flow_set, entry_digit;
  logic [3:0] entry_figure;
  logic [7:0] fv [4] = '{8'h1D, 8'h1E, 8'h64, 8'h65};
  dpbcd_mode_t op_mode;
  dpbcd_pulse_t pulse_handling;
  dpbcd_preset_t preset_kind;
  int error_cnt = 0, compares = 0, np[4] = '{0, 0, 0, 0};
  int seed = 32'he0ab;
  logic [31:0] r;
  logic [7:0] b1, b2, sf;
  logic [2:0] c;

  dpbcd_master m (.clk_sys(clk_sys), .img_valid(img_valid), .img_b1(img_b1), .img_b2(img_b2),
    .img_preset(img_preset), .img_batch_freq(img_batch_freq), .img_slow_freq(img_slow_freq), .img_b7(img_b7));
  dpbcd_decoder #(.TIMEOUT_CYC(32'h32)) dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en),
    .img_valid(img_valid), .img_b1(img_b1), .img_b2(img_b2), .img_preset(img_preset),
    .img_batch_freq(img_batch_freq), .img_slow_freq(img_slow_freq), .img_b7(img_b7), .calibrated(calibrated),
    .speed_variant(speed_variant), .scale_factor(scale_factor), .key_enter_pin(keys[0]), .key_up_pin(keys[1]),
    .key_down_pin(keys[2]), .entry_sel(entry_sel), .bus_mode(bus_mode), .station_addr(station_addr),
    .restart_req(restart_req), .entry_active(entry_active), .entry_digit(entry_digit),
    .entry_figure(entry_figure), .op_mode(op_mode),
    .fail_safe(fail_safe), .pulse_handling(pulse_handling), .pulse_mem_en(pulse_mem_en),
    .stroke_pulse(stroke_pulse), .batch_start(batch_start), .alarm_reset(alarm_reset), .ext_on(ext_on),
    .ext_stop(ext_stop), .speed_auto(speed_auto), .slow_mode(slow_mode), .single_30(single_30),
    .preset_value(preset_value),
    .preset_kind(preset_kind), .preset_dp(preset_dp), .batch_freq(batch_freq), .batch_freq_err(batch_freq_err),
    .slow_freq(slow_freq), .cnt_zero(cnt_zero), .cnt_freeze(cnt_freeze), .local_flow_set(local_flow_set));

  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys)
  begin
    np[0] += (stroke_pulse === 1'b1);
    np[1] += (batch_start === 1'b1);
    np[2] += (alarm_reset === 1'b1);
    np[3] += (restart_req === 1'b1);
  end

  task automatic chk(input logic ok, input string msg);
    compares++;
    if (ok !== 1'b1)
    begin
      error_cnt++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask : chk

  task automatic end_of_test();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_of_test

  task automatic img(input logic [7:0] a1, input logic [7:0] a2, input logic [15:0] pr, input logic [7:0] bf,
    input logic [7:0] s6, input logic [7:0] a7);
    m.send({a1, a2, pr, bf, s6, a7});
    repeat (3) @(posedge clk_sys);
    #1;
  endtask : img

  task automatic key(input int k);
    @(posedge clk_sys);
    #1;
    keys[k] = 1'b1;
    repeat (6) @(posedge clk_sys);
    #1;
    keys[k] = 1'b0;
    repeat (8) @(posedge clk_sys);
    #1;
  endtask : key

  function automatic dpbcd_preset_t exp_kind(input logic [2:0] code, input logic cal);
    case (code)
      3'h1: return PK_FACTOR;
      3'h2: return cal ? PK_FLOW_LH : PK_STROKE_PCT;
      3'h3: return cal ? PK_VOLUME_L : PK_STROKE_CNT;
      3'h4: return PK_STROKE_PCT;
      default: return PK_NONE;
    endcase
  endfunction : exp_kind

  initial
  begin
    {sys_rst, clk_en, calibrated, speed_variant, entry_sel, keys, scale_factor} = {3'b110, 13'h0000};
    repeat (8) @(posedge clk_sys);
    #1;
    sys_rst = 1'b0;
    calibrated = 1'b1;
    img(8'h01, 8'h00, 16'h0000, 8'h40, 8'h40, 8'h00);
    img(8'h01, 8'h01, 16'h0000, 8'h40, 8'h40, 8'h00);
    chk(np[0] == 0 && op_mode === OPM_NONE && bus_mode === 1'b0, "manual mode obeyed bus");
    chk(local_flow_set === 1'b1, "manual calibrated pump not set as flow");
    $display("test manual done");
    key(0);
    chk(entry_active === 1'b1, "entry not opened");
    key(1);
    keys[1] = 1'b1;
    repeat (6) @(posedge clk_sys);
    #1;
    keys[2] = 1'b1;
    repeat (6) @(posedge clk_sys);
    #1;
    keys = 3'h0;
    repeat (8) @(posedge clk_sys);
    #1;
    chk(entry_active === 1'b0 && bus_mode === 1'b0, "abort kept entry or stored");
    key(0);
    key(1);
    repeat (70) @(posedge clk_sys);
    #1;
    chk(entry_active === 1'b0 && bus_mode === 1'b0, "timeout failed");
    key(0);
    key(1);
    key(0);
    chk(entry_active === 1'b0 && bus_mode === 1'b1, "mode entry not stored");
    chk(local_flow_set === 1'b0, "flow setting left on in bus mode");
    $display("test keys done");
    for (int i = 0; i < 16; i++)
    begin
      r = $random(seed);
      c = 3'(i % 8);
      b1 = {r[7:3], c};
      b2 = {1'b0, r[15], r[8], 2'b00, r[10:9], 1'b0};
      sf = 8'(30 + (r[31:24] % 71));
      calibrated = r[11];
      speed_variant = r[12];
      scale_factor = r[23:16];
      img(b1, b2, r[31:16], 8'h50, sf, {6'h00, r[14:13]});
      chk(op_mode === dpbcd_mode_t'((c > 3'h4) ? 3'h0 : c), "op_mode");
      chk(fail_safe === (c == 3'h0 || c > 3'h4), "fail_safe");
      chk(pulse_handling === (b1[6] ? PH_MULT : (b1[5] ? PH_ONE : PH_REDUCE)), "pulse handling");
      chk(pulse_mem_en === b1[7], "pulse memory");
      chk(ext_stop === b2[2] && ext_on === (c == 3'h4 && b2[1] && !b2[2]), "ext on or stop");
      chk(speed_auto === (r[12] & r[8]) && slow_mode === (r[12] & r[15]), "speed control");
      chk(single_30 === (r[12] && r[8] && exp_kind(c, r[11]) == PK_STROKE_PCT && r[31:16] < 16'h001E), "single");
      chk(preset_kind === exp_kind(c, r[11]), "preset kind");
      chk(preset_dp === ((exp_kind(c, r[11]) inside {PK_FLOW_LH, PK_VOLUME_L}) ? r[23:16] : 8'h00), "dp");
      chk(c == 3'h0 || c > 3'h4 || preset_value === r[31:16], "preset value");
      chk(slow_freq === (r[12] ? sf : 8'h00), "slow freq");
      chk(cnt_zero === r[13] && cnt_freeze === (r[14] & ~r[13]), "counter control");
    end
    $display("test decode done");
    for (int i = 0; i < 3; i++)
    begin
      b1 = (i == 1) ? 8'h03 : 8'h01;
      b2 = 8'h01 << ((i == 0) ? 0 : ((i == 1) ? 4 : 7));
      r = np[i];
      img(b1, 8'h00, 16'h0010, 8'h50, 8'h50, 8'h00);
      img(b1, b2, 16'h0010, 8'h50, 8'h50, 8'h00);
      img(b1, b2, 16'h0010, 8'h50, 8'h50, 8'h00);
      chk(np[i] == r + 1, "edge count");
    end
    foreach (fv[j])
    begin
      sf = fv[j];
      img(8'h03, 8'h00, 16'h0010, sf, 8'h50, 8'h00);
      chk(batch_freq === sf && batch_freq_err === (sf < 8'h1E || sf > 8'h64), "batch freq");
    end
    clk_en = 1'b0;
    img(8'h02, 8'h00, 16'h0010, 8'h50, 8'h50, 8'h00);
    chk(op_mode === OPM_BATCH, "clock enable low did not freeze");
    clk_en = 1'b1;
    calibrated = 1'b0;
    speed_variant = 1'b1;
    img(8'h04, 8'h20, 16'h001D, 8'h50, 8'h50, 8'h00);
    chk(single_30 === 1'b1 && speed_auto === 1'b1, "single stroke below minimum");
    img(8'h04, 8'h20, 16'h001E, 8'h50, 8'h50, 8'h00);
    chk(single_30 === 1'b0, "single stroke at minimum");
    $display("test edges done");
    entry_sel = 1'b1;
    r = np[3];
    key(0);
    chk(entry_figure === 4'h2 && entry_digit === 1'b0, "tens digit not shown");
    key(1);
    key(0);
    chk(entry_figure === 4'h0 && entry_digit === 1'b1, "second digit not flashing");
    key(2);
    chk(entry_figure === 4'h9, "ones digit did not wrap");
    key(0);
    chk(np[3] == r + 1 && station_addr === 7'h27, "address restart");
    $display("test address done");
    end_of_test();
  end
endmodule : tb
